// >>> fpk_pkg.sv
package fpk_pkg;
    // clock and the millisecond time base
    localparam int         CLK_HZ       = 50_000_000;
    localparam int         MS_PER_S     = 1000;
    localparam int         MS_CYC       = CLK_HZ / MS_PER_S;
    // times in milliseconds, except TMO_S in seconds
    localparam logic [3:0] DEB_MS       = 4'd10;
    localparam logic [7:0] BLINK_MS     = 8'd250;
    localparam int         TMO_S        = 120;
    localparam int         TMO_MS       = TMO_S * MS_PER_S;
    localparam logic [9:0] RPT_FIRST_MS = 10'd500;
    localparam logic [9:0] RPT_START_MS = 10'd200;
    localparam logic [9:0] RPT_MIN_MS   = 10'd25;
    localparam logic [9:0] RPT_DEC_MS   = 10'd25;
    // button positions
    localparam int         B_ENT        = 0;
    localparam int         B_PLS        = 1;
    localparam int         B_MIN        = 2;
    // readout functions and settings list
    localparam logic [3:0] FN_LAST      = 4'hc;
    localparam logic [3:0] FN_TEST      = 4'hb;
    localparam logic [3:0] FN_LINE_BUS  = 4'hc;
    localparam logic [4:0] SET_LAST     = 5'h13;
    localparam logic [4:0] SET_FIRST_PROT = 5'h01;
    localparam logic [4:0] SET_LINE_LIVE  = 5'h08;
    localparam logic [4:0] SET_LINE_DEAD  = 5'h09;
    localparam logic [4:0] SET_BUS_LIVE   = 5'h0a;
    localparam logic [4:0] SET_BUS_DEAD   = 5'h0b;
    // segment bits {dp,g,f,e,d,c,b,a}
    localparam logic [7:0] SEG_OFF      = 8'h00;
    localparam logic [7:0] SEG_ALL      = 8'hff;
    localparam logic [7:0] SEG_TOP      = 8'h01;
    localparam logic [7:0] SEG_BOT      = 8'h08;
    localparam logic [7:0] SEG_MID      = 8'h40;

    typedef enum logic [1:0] {ST_READOUT = 2'b00, ST_CODE = 2'b01, ST_VALUE = 2'b10} fpk_state_e;
    typedef struct packed {logic [7:0] left; logic [7:0] mid; logic [7:0] right;} fpk_disp_s;
    typedef struct packed {logic manual; logic close_permit; logic breaker_aux;} fpk_din_s;
    typedef struct packed {logic ready; logic close_enable; logic undervoltage;} fpk_led_s;
    typedef struct packed {logic [3:0] grp; logic [3:0] num; logic [9:0] min; logic [9:0] max;
                           logic [9:0] dflt;} fpk_set_s;

    // setting code, range and default, values counted in steps
    function automatic fpk_set_s set_info(input logic [4:0] i);
        case (i)
            5'h00: return '{4'h0, 4'h1, 10'd0, 10'd1, 10'd0};
            5'h01: return '{4'h1, 4'h1, 10'd4, 10'd180, 10'd30};
            5'h02: return '{4'h1, 4'h2, 10'd2, 10'd60, 10'd10};
            5'h03: return '{4'h1, 4'h3, 10'd1, 10'd50, 10'd2};
            5'h04: return '{4'h1, 4'h4, 10'd1, 10'd990, 10'd1};
            5'h05: return '{4'h1, 4'h5, 10'd1, 10'd990, 10'd101};
            5'h06: return '{4'h2, 4'h1, 10'd0, 10'd1, 10'd0};
            5'h07: return '{4'h2, 4'h2, 10'd10, 10'd180, 10'd40};
            5'h08: return '{4'h3, 4'h1, 10'd40, 10'd245, 10'd50};
            5'h09: return '{4'h3, 4'h2, 10'd10, 10'd180, 10'd30};
            5'h0a: return '{4'h3, 4'h3, 10'd40, 10'd245, 10'd50};
            5'h0b: return '{4'h3, 4'h4, 10'd10, 10'd180, 10'd30};
            5'h0c: return '{4'h4, 4'h1, 10'd0, 10'd1, 10'd0};
            5'h0d: return '{4'h4, 4'h2, 10'd0, 10'd1, 10'd0};
            5'h0e: return '{4'h4, 4'h3, 10'd0, 10'd1, 10'd0};
            5'h0f: return '{4'h4, 4'h4, 10'd0, 10'd1, 10'd0};
            5'h10: return '{4'h5, 4'h1, 10'd0, 10'd6, 10'd1};
            5'h11: return '{4'h5, 4'h2, 10'd0, 10'd6, 10'd2};
            5'h12: return '{4'h6, 4'h1, 10'd1, 10'd255, 10'd1};
            default: return '{4'h6, 4'h2, 10'd0, 10'd7, 10'd5};
        endcase
    endfunction

    // hex digit to segments
    function automatic logic [7:0] hex_seg(input logic [3:0] d);
        case (d)
            4'h0: return 8'h3f;
            4'h1: return 8'h06;
            4'h2: return 8'h5b;
            4'h3: return 8'h4f;
            4'h4: return 8'h66;
            4'h5: return 8'h6d;
            4'h6: return 8'h7d;
            4'h7: return 8'h07;
            4'h8: return 8'h7f;
            4'h9: return 8'h6f;
            4'ha: return 8'h77;
            4'hb: return 8'h7c;
            4'hc: return 8'h39;
            4'hd: return 8'h5e;
            4'he: return 8'h79;
            default: return 8'h71;
        endcase
    endfunction

    // binary to three decimal digits
    function automatic logic [11:0] to_bcd(input logic [9:0] v);
        logic [21:0] s;
        s = {12'h000, v};
        for (int i = 0; i < 10; i++) begin
            for (int d = 0; d < 3; d++) begin
                if (s[10+4*d +: 4] > 4'd4) s[10+4*d +: 4] = s[10+4*d +: 4] + 4'd3;
            end
            s = s << 1;
        end
        return s[21:10];
    endfunction
endpackage

// >>> fpk_front_panel_menu.sv
`timescale 1ns/10ps
module fpk_front_panel_menu #(
    parameter int MS_DIV     = fpk_pkg::MS_CYC,
    parameter int TIMEOUT_MS = fpk_pkg::TMO_MS,
    parameter int N_OUT      = 4
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               reset,
    // pushbuttons, high while pressed
    input  wire logic               btn_enter,
    input  wire logic               btn_plus,
    input  wire logic               btn_minus,
    // digital inputs, pin level
    input  wire fpk_pkg::fpk_din_s  din,
    // protection state on the same clock
    input  wire fpk_pkg::fpk_led_s  led_status,
    input  wire logic [7:0]         line_volts,
    input  wire logic [7:0]         bus_volts,
    input  wire fpk_pkg::fpk_disp_s readout_disp,
    input  wire logic [N_OUT-1:0]   unit_out,
    // front panel
    output fpk_pkg::fpk_disp_s      disp,
    output fpk_pkg::fpk_led_s       led,
    // to the rest of the relay
    output logic [3:0]              readout_fn,
    output logic                    in_setting,
    output logic                    nvm_wr,
    output logic [4:0]              nvm_index,
    output logic [9:0]              nvm_data,
    output logic                    prot_restart,
    output logic [N_OUT-1:0]        relay_out
);
    import fpk_pkg::*;

    localparam int MSW = $clog2(MS_DIV);
    localparam int TW  = $clog2(TIMEOUT_MS + 1);

    logic [MSW-1:0]   ms_cnt_r;
    logic             ms_tick_r;
    logic [2:0]       btn_pin, btn_s1_r, btn_s2_r, btn_r, btn_prev_r, press;
    fpk_din_s         din_s1_r, din_s2_r;
    logic [7:0]       blink_cnt_r;
    logic             blink_r;
    logic [9:0]       rpt_cnt_r, rpt_ivl_r;
    logic             rpt_r, hold_one, step_up, step_dn, combo, tmo, commit;
    logic [TW-1:0]    tmo_cnt_r;
    fpk_state_e       state_r;
    logic [3:0]       fn_r;
    logic [4:0]       idx_r;
    logic [9:0]       pend_r, cur_set;
    logic [9:0]       set_mem_r [0:SET_LAST];
    fpk_set_s         si;
    logic [N_OUT-1:0] drop_r;
    fpk_disp_s        disp_nxt;
    fpk_led_s         led_nxt;
    logic [11:0]      fn_dig, val_dig;

    // one-cycle enable every millisecond
    always_ff @(posedge mclk) begin
        if (reset || ms_cnt_r == MSW'(MS_DIV - 1)) begin
            ms_cnt_r <= '0;
        end else begin
            ms_cnt_r <= ms_cnt_r + 1'b1;
        end
        ms_tick_r <= !reset && ms_cnt_r == MSW'(MS_DIV - 1);
    end

    // two-stage synchronisers for buttons and digital inputs
    assign btn_pin = {btn_minus, btn_plus, btn_enter};
    always_ff @(posedge mclk) begin
        btn_s1_r <= btn_pin;
        btn_s2_r <= btn_s1_r;
        din_s1_r <= din;
        din_s2_r <= din_s1_r;
    end

    // debounce: level must hold through DEB_MS millisecond ticks
    for (genvar g = 0; g < 3; g++) begin : g_deb
        logic [3:0] cnt_r;
        always_ff @(posedge mclk) begin
            if (reset) begin
                cnt_r    <= '0;
                btn_r[g] <= 1'b0;
            end else if (btn_s2_r[g] == btn_r[g]) begin
                cnt_r <= '0;
            end else if (ms_tick_r) begin
                if (cnt_r == DEB_MS - 4'd1) begin
                    cnt_r    <= '0;
                    btn_r[g] <= btn_s2_r[g];
                end else begin
                    cnt_r <= cnt_r + 4'd1;
                end
            end
        end
    end

    // press edges and key combinations
    always_ff @(posedge mclk) begin
        btn_prev_r <= reset ? 3'b000 : btn_r;
    end
    assign press   = btn_r & ~btn_prev_r;
    assign combo   = btn_r[B_PLS] && btn_r[B_MIN] && (press[B_PLS] || press[B_MIN]);
    assign step_up = !btn_r[B_MIN] && (press[B_PLS] || (rpt_r && btn_r[B_PLS]));
    assign step_dn = !btn_r[B_PLS] && (press[B_MIN] || (rpt_r && btn_r[B_MIN]));

    // flash phase for blinking digits and leds
    always_ff @(posedge mclk) begin
        if (reset) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b1;
        end else if (ms_tick_r) begin
            if (blink_cnt_r == BLINK_MS - 8'd1) begin
                blink_cnt_r <= '0;
                blink_r     <= !blink_r;
            end else begin
                blink_cnt_r <= blink_cnt_r + 8'd1;
            end
        end
    end

    // auto-repeat: first gap long, then each gap shorter down to a floor
    assign hold_one = state_r == ST_VALUE && (btn_r[B_PLS] ^ btn_r[B_MIN]);
    always_ff @(posedge mclk) begin
        if (reset || !hold_one || press[B_PLS] || press[B_MIN]) begin
            rpt_cnt_r <= '0;
            rpt_ivl_r <= RPT_FIRST_MS;
            rpt_r     <= 1'b0;
        end else begin
            rpt_r <= 1'b0;
            if (ms_tick_r) begin
                if (rpt_cnt_r == rpt_ivl_r - 10'd1) begin
                    rpt_r     <= 1'b1;
                    rpt_cnt_r <= '0;
                    if (rpt_ivl_r == RPT_FIRST_MS) rpt_ivl_r <= RPT_START_MS;
                    else if (rpt_ivl_r > RPT_MIN_MS + RPT_DEC_MS) rpt_ivl_r <= rpt_ivl_r - RPT_DEC_MS;
                    else rpt_ivl_r <= RPT_MIN_MS;
                end else begin
                    rpt_cnt_r <= rpt_cnt_r + 10'd1;
                end
            end
        end
    end

    // inactivity timer, held clear while any button is down or outside settings
    always_ff @(posedge mclk) begin
        if (reset || state_r == ST_READOUT || btn_r != 3'b000) begin
            tmo_cnt_r <= '0;
        end else if (ms_tick_r && !tmo) begin
            tmo_cnt_r <= tmo_cnt_r + 1'b1;
        end
    end
    assign tmo = tmo_cnt_r == TW'(TIMEOUT_MS);

    assign si      = set_info(idx_r);
    assign cur_set = set_mem_r[idx_r];
    assign commit  = state_r == ST_VALUE && !combo && !tmo && press[B_ENT] && pend_r != cur_set;

    // menu state machine
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r <= ST_READOUT;
            fn_r    <= FN_LINE_BUS;
            idx_r   <= SET_FIRST_PROT;
            pend_r  <= '0;
        end else begin
            case (state_r)
                ST_READOUT: begin
                    if (btn_r[B_ENT] && press[B_MIN]) begin
                        state_r <= ST_CODE;
                        idx_r   <= SET_FIRST_PROT;
                    end else if (press[B_ENT] && !btn_r[B_PLS] && !btn_r[B_MIN]) begin
                        fn_r <= (fn_r == FN_LAST) ? 4'h0 : fn_r + 4'h1;
                    end
                end
                ST_CODE: begin
                    if (combo || tmo) begin
                        state_r <= ST_READOUT;
                        fn_r    <= FN_LINE_BUS;
                    end else if (press[B_ENT]) begin
                        state_r <= ST_VALUE;
                        pend_r  <= cur_set;
                    end else if (step_up && press[B_PLS]) begin
                        idx_r <= (idx_r == SET_LAST) ? 5'h00 : idx_r + 5'h01;
                    end else if (step_dn && press[B_MIN]) begin
                        idx_r <= (idx_r == 5'h00) ? SET_LAST : idx_r - 5'h01;
                    end
                end
                ST_VALUE: begin
                    if (combo || tmo) begin
                        state_r <= ST_READOUT;
                        fn_r    <= FN_LINE_BUS;
                    end else if (press[B_ENT]) begin
                        state_r <= ST_CODE;
                    end else if (step_up && pend_r < si.max) begin
                        pend_r <= pend_r + 10'd1;
                    end else if (step_dn && pend_r > si.min) begin
                        pend_r <= pend_r - 10'd1;
                    end
                end
                default: state_r <= ST_READOUT;
            endcase
        end
    end

    // stored settings and the write to non-volatile memory
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i <= SET_LAST; i++) set_mem_r[i] <= dflt_of(5'(i));
            nvm_wr       <= 1'b0;
            nvm_index    <= '0;
            nvm_data     <= '0;
            prot_restart <= 1'b0;
        end else begin
            nvm_wr       <= commit;
            prot_restart <= commit;
            if (commit) begin
                set_mem_r[idx_r] <= pend_r;
                nvm_index        <= idx_r;
                nvm_data         <= pend_r;
            end
        end
    end

    // outputs drop on restart until their unit lets go and asserts again
    always_ff @(posedge mclk) begin
        if (reset) begin
            drop_r    <= '0;
            relay_out <= '0;
        end else begin
            drop_r    <= commit ? {N_OUT{1'b1}} : (drop_r & unit_out);
            relay_out <= commit ? '0 : (unit_out & ~drop_r);
        end
    end

    // line or bus state on one digit
    function automatic logic [7:0] lb_seg(input logic [7:0] v, input logic [9:0] live, input logic [9:0] dead);
        logic [9:0] w;
        w = {2'b00, v};
        return ((w >= live) ? SEG_TOP : SEG_OFF) | ((w < dead) ? SEG_BOT : SEG_OFF) |
               ((w < live && w >= dead) ? SEG_MID : SEG_OFF);
    endfunction
    // factory default of one setting
    function automatic logic [9:0] dflt_of(input logic [4:0] i);
        fpk_set_s s = set_info(i);
        return s.dflt;
    endfunction

    // display and led selection
    assign fn_dig  = to_bcd({6'b000000, fn_r});
    assign val_dig = to_bcd(pend_r);
    always_comb begin
        disp_nxt = readout_disp;
        led_nxt  = led_status;
        case (state_r)
            ST_READOUT: begin
                if (btn_r[B_ENT]) begin
                    disp_nxt = '{hex_seg(4'hf), (fn_r > 4'h9) ? hex_seg(fn_dig[7:4]) : hex_seg(fn_dig[3:0]),
                                 (fn_r > 4'h9) ? hex_seg(fn_dig[3:0]) : SEG_OFF};
                end else if (fn_r == FN_TEST) begin
                    disp_nxt = {3{blink_r ? SEG_ALL : SEG_OFF}};
                    led_nxt  = '{din_s2_r.manual ? blink_r : 1'b1,
                                 din_s2_r.close_permit ? blink_r : 1'b1,
                                 din_s2_r.breaker_aux ? blink_r : 1'b1};
                end else if (fn_r == FN_LINE_BUS) begin
                    disp_nxt = '{lb_seg(line_volts, set_mem_r[SET_LINE_LIVE], set_mem_r[SET_LINE_DEAD]),
                                 SEG_OFF, lb_seg(bus_volts, set_mem_r[SET_BUS_LIVE], set_mem_r[SET_BUS_DEAD])};
                end
            end
            ST_CODE: disp_nxt = '{hex_seg(si.grp), SEG_MID, hex_seg(si.num)};
            ST_VALUE: disp_nxt = blink_r ? {hex_seg(val_dig[11:8]), hex_seg(val_dig[7:4]), hex_seg(val_dig[3:0])}
                                         : {3{SEG_OFF}};
            default: disp_nxt = readout_disp;
        endcase
    end

    // registered panel and status outputs
    always_ff @(posedge mclk) begin
        if (reset) begin
            disp       <= '{SEG_OFF, SEG_OFF, SEG_OFF};
            led        <= '{1'b0, 1'b0, 1'b0};
            readout_fn <= FN_LINE_BUS;
            in_setting <= 1'b0;
        end else begin
            disp       <= disp_nxt;
            led        <= led_nxt;
            readout_fn <= fn_r;
            in_setting <= state_r != ST_READOUT;
        end
    end

    chk_test_flash: assert property (@(posedge mclk) disable iff (reset)
        state_r == ST_READOUT && fn_r == FN_TEST && !btn_r[B_ENT] |=> disp.mid == ($past(blink_r) ? SEG_ALL : SEG_OFF))
        else $error("display test segments wrong");
    chk_test_led: assert property (@(posedge mclk) disable iff (reset)
        state_r == ST_READOUT && fn_r == FN_TEST && !btn_r[B_ENT] && !din_s2_r.breaker_aux |=> led.undervoltage)
        else $error("inactive input led not steady");
    chk_line_live: assert property (@(posedge mclk) disable iff (reset)
        state_r == ST_READOUT && fn_r == FN_LINE_BUS && !btn_r[B_ENT] && {2'b00, line_volts} >= set_mem_r[SET_LINE_LIVE]
        |=> disp.left[0])
        else $error("live line not shown");
    chk_enter_set: assert property (@(posedge mclk) disable iff (reset)
        state_r == ST_READOUT && btn_r[B_ENT] && press[B_MIN] |=> state_r == ST_CODE && idx_r == SET_FIRST_PROT ##1 in_setting)
        else $error("setting entry failed");
    chk_combo_exit: assert property (@(posedge mclk) disable iff (reset)
        state_r != ST_READOUT && combo |=> state_r == ST_READOUT && !nvm_wr)
        else $error("combination did not leave settings");
    chk_tmo_exit: assert property (@(posedge mclk) disable iff (reset)
        state_r != ST_READOUT && tmo |=> state_r == ST_READOUT)
        else $error("timeout did not leave settings");
    chk_store_wait: assert property (@(posedge mclk) disable iff (reset)
        state_r == ST_VALUE && !press[B_ENT] |=> $stable(cur_set))
        else $error("setting stored before confirm");
    chk_commit_out: assert property (@(posedge mclk) disable iff (reset)
        commit |=> nvm_wr && prot_restart && nvm_data == $past(pend_r) && relay_out == '0 ##1 !nvm_wr)
        else $error("commit pulses wrong");
    chk_saturate: assert property (@(posedge mclk) disable iff (reset)
        state_r == ST_VALUE && step_up && pend_r == si.max |=> $stable(pend_r))
        else $error("value passed maximum");
endmodule // fpk_front_panel_menu

// >>> fpk_operator.sv
`timescale 1ns/10ps
// operator at the front panel, changes buttons on the falling edge
module fpk_operator (
    // clock
    input  wire logic mclk,
    // pushbutton pins, high while pressed
    output logic      btn_enter,
    output logic      btn_plus,
    output logic      btn_minus
);
    // all buttons released at power-up
    initial {btn_minus, btn_plus, btn_enter} = 3'h0;

    // press {minus,plus,enter} for hold cycles, then rest long enough to debounce
    task automatic push(input logic [2:0] b, input int hold);
        @(negedge mclk) {btn_minus, btn_plus, btn_enter} = b;
        repeat (hold) @(negedge mclk);
        {btn_minus, btn_plus, btn_enter} = 3'h0;
        repeat (60) @(negedge mclk);
    endtask

    // confirm is held down first, minus comes while it stays down
    task automatic enter_set();
        @(negedge mclk) btn_enter = 1'b1;
        repeat (60) @(negedge mclk);
        btn_minus = 1'b1;
        repeat (60) @(negedge mclk);
        {btn_minus, btn_enter} = 2'h0;
        repeat (60) @(negedge mclk);
    endtask
endmodule // fpk_operator

// >>> test_front_panel_keypad_menu.sv
`timescale 1ns/10ps
module test_front_panel_keypad_menu;
    import fpk_pkg::*;
    logic       mclk, reset, btn_enter, btn_plus, btn_minus, in_setting, nvm_wr, prot_restart, rst_ok;
    fpk_din_s   din;
    fpk_led_s   led_status, led;
    fpk_disp_s  readout_disp, disp;
    logic [7:0] line_volts, bus_volts;
    logic [3:0] unit_out, relay_out, readout_fn;
    logic [4:0] nvm_index;
    logic [9:0] nvm_data;
    int         n_fail = 0, checks = 0, n_wr = 0, n_on = 0, n_off = 0, n_blink = 0;

    // short time base: 4 cycles per ms, 50 ms timeout
    fpk_front_panel_menu #(.MS_DIV(4), .TIMEOUT_MS(50), .N_OUT(4)) DUT (.mclk(mclk), .reset(reset),
        .btn_enter(btn_enter), .btn_plus(btn_plus), .btn_minus(btn_minus), .din(din), .led_status(led_status),
        .line_volts(line_volts), .bus_volts(bus_volts), .readout_disp(readout_disp), .unit_out(unit_out),
        .disp(disp), .led(led), .readout_fn(readout_fn), .in_setting(in_setting), .nvm_wr(nvm_wr),
        .nvm_index(nvm_index), .nvm_data(nvm_data), .prot_restart(prot_restart), .relay_out(relay_out));
    fpk_operator op (.mclk(mclk), .btn_enter(btn_enter), .btn_plus(btn_plus), .btn_minus(btn_minus));

    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // count memory writes and see the restart pulse beside each
    always @(negedge mclk) if (nvm_wr === 1'b1) begin
        n_wr++;
        rst_ok = (prot_restart === 1'b1);
    end

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        din = 3'b100;
        led_status = 3'h0;
        line_volts = 8'd100;
        bus_volts = 8'd20;
        readout_disp = 24'h000000;
        unit_out = 4'hf;
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        repeat (4) @(negedge mclk);
        // line live on the left, bus dead on the right
        chk(disp.left === SEG_TOP && disp.right === SEG_BOT && readout_fn === 4'hc, "line bus view");
        line_volts = 8'd40;
        repeat (4) @(negedge mclk);
        chk(disp.left === SEG_MID && in_setting === 1'b0, "between thresholds");
        $display("line bus view done");
        // twelve confirm presses walk from the last function to the test function
        for (int i = 0; i < 12; i++) op.push(3'b001, 60);
        chk(readout_fn === FN_TEST, "readout advance");
        for (int i = 0; i < 2500; i++) begin
            @(negedge mclk);
            n_on += (disp === 24'hffffff);
            n_off += (disp === 24'h000000);
            n_blink += (led.ready === 1'b0);
            chk(led.close_enable === 1'b1 && led.undervoltage === 1'b1, "steady leds");
        end
        chk(n_on > 0 && n_off > 0, "segments flash");
        chk(n_blink > 0 && n_blink < 2500, "manual input blinks ready");
        $display("display test done");
        op.enter_set();
        chk(in_setting === 1'b1 && disp.left === 8'h06 && disp.right === 8'h06, "first code");
        op.push(3'b010, 60);
        chk(disp.right === 8'h5b, "next code");
        op.push(3'b010, 60);
        op.push(3'b001, 60);
        chk(relay_out === 4'hf, "outputs before change");
        for (int i = 0; i < 5; i++) op.push(3'b010, 60);
        chk(n_wr == 0, "pending not stored");
        op.push(3'b001, 60);
        chk(n_wr == 1 && rst_ok && nvm_index === 5'h03 && nvm_data === 10'd7, "stored change");
        chk(relay_out === 4'h0 && disp.right === 8'h4f, "outputs drop, code back");
        unit_out = 4'h0;
        repeat (3) @(negedge mclk);
        unit_out = 4'hf;
        repeat (3) @(negedge mclk);
        chk(relay_out === 4'hf, "outputs reasserted");
        $display("edit done");
        for (int i = 0; i < 3; i++) op.push(3'b100, 60);
        chk(disp.left === 8'h3f && disp.right === 8'h06, "previous code");
        op.push(3'b001, 60);
        op.push(3'b100, 60);
        op.push(3'b001, 60);
        chk(n_wr == 1, "minus at minimum, no write");
        op.push(3'b001, 60);
        op.push(3'b010, 60);
        op.push(3'b010, 60);
        op.push(3'b001, 60);
        chk(n_wr == 2 && nvm_data === 10'd1, "plus saturates");
        op.push(3'b010, 60);
        op.push(3'b010, 60);
        op.push(3'b001, 60);
        op.push(3'b010, 3200);
        op.push(3'b001, 60);
        chk(n_wr == 3 && nvm_index === 5'h02 && nvm_data === 10'd13, "auto repeat");
        $display("saturation and repeat done");
        op.push(3'b001, 60);
        op.push(3'b010, 60);
        op.push(3'b110, 60);
        chk(in_setting === 1'b0 && readout_fn === 4'hc && n_wr == 3, "combo exit discards");
        op.enter_set();
        chk(in_setting === 1'b1, "back in settings");
        for (int i = 0; i < 600 && in_setting !== 1'b0; i++) @(negedge mclk);
        chk(in_setting === 1'b0 && n_wr == 3, "inactivity timeout");
        $display("exit done");
        end_of_test();
    end
endmodule // test_front_panel_keypad_menu
